// file: core/qtw_timers.sv
// quad timer block with watchdog, APB register slave
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "qtw_cfg.svh"

// ------------------------------------------------------------
// one timer channel
// ------------------------------------------------------------
module qtw_counter #(
  parameter int W = 16,
  parameter bit UP_OK = 1'b0,
  parameter bit HMS_OK = 1'b0,
  parameter bit DOG_OK = 1'b0,
  parameter bit SRC_SEL = 1'b0,
  parameter logic [1:0] SRC_FIX = 2'd1
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ld_we_i,
  input wire logic ctl_we_i,
  input wire logic clr_we_i,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] src_i,
  output logic [W-1:0] count_o,
  output logic [W-1:0] load_o,
  output logic [`QTW_CTRL_W-1:0] ctrl_o,
  output logic irq_o,
  output logic event_o,
  output logic bite_o
);
  import qtw_pkg::*;

  localparam int HLO[4] = `QTW_HMS_LO;
  localparam logic [6:0] HMX[4] = `QTW_HMS_MAX;

  if (W != 16 && W != 32) begin : g_bad_w
    $error("qtw_counter: width must be 16 or 32");
  end
  if (HMS_OK && W != 32) begin : g_bad_hms
    $error("qtw_counter: time-of-day format needs 32 bits");
  end

  // time-of-day step with carry or borrow between fields
  function automatic logic [31:0] hms_step(input logic [31:0] v, input logic up);
    logic [31:0] r;
    logic c;
    logic [6:0] f;
    logic [6:0] nf;
    r = v;
    c = 1'b1;
    for (int i = 0; i < 4; i++) begin
      f = 7'(v >> HLO[i]);
      nf = f;
      if (c) begin
        if (up) begin
          nf = (f == HMX[i]) ? 7'h00 : 7'(f + 7'h01);
          c = (f == HMX[i]);
        end else begin
          nf = (f == 7'h00) ? HMX[i] : 7'(f - 7'h01);
          c = (f == 7'h00);
        end
      end
      r = (r & ~(32'h0000007f << HLO[i])) | (32'(nf) << HLO[i]);
    end
    return r;
  endfunction

  logic [W-1:0] count_reg;
  logic [W-1:0] load_reg;
  logic [`QTW_CTRL_W-1:0] ctrl_reg;
  logic [14:0] pre_reg;
  logic irq_reg;
  logic event_reg;
  logic bite_reg;

  logic dog_on;
  logic hms;
  logic up;
  logic periodic;
  logic src_tick;
  logic step;
  logic at_limit;
  logic [14:0] pre_lim;
  logic [W-1:0] full;
  logic [W-1:0] step_val;
  logic [W-1:0] wrap_val;
  logic [W-1:0] start_val;
  logic [W-1:0] start_full;

  assign dog_on = DOG_OK && ctrl_reg[`QTW_CB_DOGEN];
  assign hms = HMS_OK && (ctrl_reg[`QTW_CB_FMT_LO+:2] == `QTW_FMT_HMS);
  assign up = UP_OK && ctrl_reg[`QTW_CB_UP] && !dog_on;
  assign periodic = ctrl_reg[`QTW_CB_PER] || dog_on;
  assign src_tick = SRC_SEL ? src_i[ctrl_reg[`QTW_CB_SRC_LO+:2]] : src_i[SRC_FIX];

  always_comb begin
    case (qtw_pre_t'(ctrl_reg[`QTW_CB_PRE_LO+:2]))
      QTW_PRE_1: pre_lim = `QTW_PRE_LIM1;
      QTW_PRE_16: pre_lim = `QTW_PRE_LIM16;
      QTW_PRE_256: pre_lim = `QTW_PRE_LIM256;
      QTW_PRE_32K: pre_lim = (W == 32) ? `QTW_PRE_LIM32K : `QTW_PRE_LIM256;
      default: pre_lim = `QTW_PRE_LIM1;
    endcase
  end

  assign step = ctrl_reg[`QTW_CB_EN] && src_tick && (pre_reg == pre_lim);
  assign full = hms ? W'(`QTW_HMS_FULL) : {W{1'b1}};
  assign at_limit = up ? (count_reg == full) : (count_reg == '0);
  assign step_val = hms ? W'(hms_step(32'(count_reg), up)) :
                    (up ? W'(count_reg + 1'b1) : W'(count_reg - 1'b1));
  assign wrap_val = periodic ? load_reg : (up ? '0 : full);
  assign start_full = (HMS_OK && wdata_i[`QTW_CB_FMT_LO+:2] == `QTW_FMT_HMS) ?
                      W'(`QTW_HMS_FULL) : {W{1'b1}};
  assign start_val = (wdata_i[`QTW_CB_PER] || (DOG_OK && wdata_i[`QTW_CB_DOGEN])) ? load_reg :
                     ((UP_OK && wdata_i[`QTW_CB_UP]) ? '0 : start_full);

  // load and control, locked once watchdog mode is on
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      load_reg <= '0;
      ctrl_reg <= `QTW_CTRL_RESET;
    end else if (!dog_on) begin
      if (ld_we_i) begin
        load_reg <= wdata_i[W-1:0];
      end
      if (ctl_we_i) begin
        ctrl_reg <= wdata_i[`QTW_CTRL_W-1:0];
      end
    end
  end

  // prescaler
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_reg <= '0;
    end else if ((ctl_we_i && !dog_on) || (clr_we_i && dog_on) || step) begin
      pre_reg <= '0;
    end else if (ctrl_reg[`QTW_CB_EN] && src_tick) begin
      pre_reg <= 15'(pre_reg + 15'h0001);
    end
  end

  // counter
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg <= '0;
    end else if (ctl_we_i && !dog_on) begin
      count_reg <= start_val;
    end else if (clr_we_i && dog_on) begin
      count_reg <= load_reg;
    end else if (step) begin
      count_reg <= at_limit ? wrap_val : step_val;
    end
  end

  // pending interrupt: a new event wins over a clear in the same cycle
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_reg <= 1'b0;
    end else if (step && at_limit && !(dog_on && ctrl_reg[`QTW_CB_DOGRST])) begin
      irq_reg <= 1'b1;
    end else if (clr_we_i) begin
      irq_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      event_reg <= 1'b0;
      bite_reg <= 1'b0;
    end else begin
      event_reg <= step && at_limit;
      bite_reg <= step && at_limit && dog_on && ctrl_reg[`QTW_CB_DOGRST];
    end
  end

  assign count_o = count_reg;
  assign load_o = load_reg;
  assign ctrl_o = ctrl_reg;
  assign irq_o = irq_reg;
  assign event_o = event_reg;
  assign bite_o = bite_reg;
endmodule

// ------------------------------------------------------------
// top: four timers, clock-source synchronisers, APB slave
// ------------------------------------------------------------
module qtw_timers (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic xtal32k_i,
  input wire logic osc32k_i,
  input wire logic ext_clk_i,
  input wire logic core_gated_i,
  input wire logic [31:0] irq_src_i,
  output logic [3:0] irq_o,
  output logic adc_start_o,
  output logic chip_reset_o
);
  import qtw_pkg::*;

  localparam int WID[4] = '{16, 32, 32, 16};

  // ------------------------------------------------------------
  // synchronisers for the slow clock sources
  // ------------------------------------------------------------
  logic [2:0] sync_reg [3];
  logic [2:0] lvl_reg;
  logic [2:0] lvl_prev_reg;
  logic [2:0] async_in;
  logic [2:0] rise;

  assign async_in = {ext_clk_i, osc32k_i, xtal32k_i};

  for (genvar s = 0; s < 3; s++) begin : g_sync
    always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
        sync_reg[s] <= 3'h0;
        lvl_reg[s] <= 1'b0;
        lvl_prev_reg[s] <= 1'b0;
      end else begin
        sync_reg[s] <= {sync_reg[s][1:0], async_in[s]};
        if (sync_reg[s][1] == sync_reg[s][2]) begin
          lvl_reg[s] <= sync_reg[s][2];
        end
        lvl_prev_reg[s] <= lvl_reg[s];
      end
    end
    assign rise[s] = lvl_reg[s] && !lvl_prev_reg[s];
  end

  logic core_tick;
  assign core_tick = !core_gated_i;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  logic setup;
  logic wr_acc;
  logic [1:0] tsel;
  logic [4:0] tofs;
  logic [3:0] ld_we;
  logic [3:0] ctl_we;
  logic [3:0] clr_we;

  assign setup = psel_i && !penable_i;
  assign wr_acc = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
  assign tsel = paddr_i[6:5];
  assign tofs = paddr_i[4:0];

  for (genvar t = 0; t < 4; t++) begin : g_we
    assign ld_we[t] = wr_acc && !paddr_i[7] && tsel == 2'(t) && tofs == `QTW_OFS_LOAD;
    assign ctl_we[t] = wr_acc && !paddr_i[7] && tsel == 2'(t) && tofs == `QTW_OFS_CTRL;
    assign clr_we[t] = wr_acc && !paddr_i[7] && tsel == 2'(t) && tofs == `QTW_OFS_CLEAR;
  end

  // ------------------------------------------------------------
  // timer channels
  // ------------------------------------------------------------
  logic [31:0] cnt [4];
  logic [31:0] ld [4];
  logic [`QTW_CTRL_W-1:0] ctl [4];
  logic [3:0] irq;
  logic [3:0] evt;
  logic [3:0] bite;

  for (genvar t = 0; t < 4; t++) begin : g_tmr
    logic [3:0] src;
    assign src = (t == 2) ? {rise[1], rise[1], core_tick, rise[0]} :
                            {rise[1], rise[2], core_tick, rise[0]};
    if (WID[t] < 32) begin : g_pad
      assign cnt[t][31:WID[t]] = '0;
      assign ld[t][31:WID[t]] = '0;
    end
    qtw_counter #(
      .W(WID[t]),
      .UP_OK(t != 0),
      .HMS_OK(t == 1 || t == 2),
      .DOG_OK(t == 3),
      .SRC_SEL(t == 1 || t == 2),
      .SRC_FIX((t == 3) ? 2'(QTW_SRC_OSC) : 2'(QTW_SRC_CORE))
    ) u_tmr (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .ld_we_i(ld_we[t]),
      .ctl_we_i(ctl_we[t]),
      .clr_we_i(clr_we[t]),
      .wdata_i(pwdata_i),
      .src_i(src),
      .count_o(cnt[t][WID[t]-1:0]),
      .load_o(ld[t][WID[t]-1:0]),
      .ctrl_o(ctl[t]),
      .irq_o(irq[t]),
      .event_o(evt[t]),
      .bite_o(bite[t])
    );
  end

  // ------------------------------------------------------------
  // capture on the first assertion of the chosen source
  // ------------------------------------------------------------
  logic cap_prev_reg;
  logic cap_src;
  logic [31:0] capture_reg;

  assign cap_src = irq_src_i[ctl[1][`QTW_CB_CAP_LO+:5]];

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cap_prev_reg <= 1'b0;
      capture_reg <= '0;
    end else begin
      cap_prev_reg <= cap_src;
      if (cap_src && !cap_prev_reg) begin
        capture_reg <= cnt[1];
      end
    end
  end

  // ------------------------------------------------------------
  // block outputs
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 4'h0;
      adc_start_o <= 1'b0;
      chip_reset_o <= 1'b0;
    end else begin
      irq_o <= irq;
      adc_start_o <= (evt[0] && ctl[0][`QTW_CB_ADCEN]) || (evt[1] && ctl[1][`QTW_CB_ADCEN]);
      chip_reset_o <= bite[3];
    end
  end

  // ------------------------------------------------------------
  // APB read path and answer, one access cycle
  // ------------------------------------------------------------
  logic [31:0] rd_data;
  logic rd_err;

  always_comb begin
    rd_data = 32'h00000000;
    rd_err = 1'b0;
    if (paddr_i[1:0] != 2'b00) begin
      rd_err = 1'b1;
    end else if (paddr_i == `QTW_OFS_STATUS) begin
      rd_data = {27'h0000000, ctl[3][`QTW_CB_DOGEN], irq};
    end else if (paddr_i[7]) begin
      rd_err = 1'b1;
    end else begin
      case (tofs)
        `QTW_OFS_LOAD: rd_data = ld[tsel];
        `QTW_OFS_COUNT: rd_data = cnt[tsel];
        `QTW_OFS_CTRL: rd_data = 32'(ctl[tsel]);
        `QTW_OFS_CLEAR: rd_data = 32'h00000000;
        `QTW_OFS_CAPTURE: begin
          if (tsel == `QTW_GP_TIMER) begin
            rd_data = capture_reg;
          end else begin
            rd_err = 1'b1;
          end
        end
        default: rd_err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else if (setup) begin
      pready_o <= 1'b1;
      pslverr_o <= rd_err;
      prdata_o <= pwrite_i ? 32'h00000000 : rd_data;
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// file: core/qtw_cfg.svh
// constants of the quad timer block: register map, control fields, formats
// Function
// - free-running: down wraps zero to maximum, up wraps full scale to zero
// - periodic: count from load value to limit, then restart from load value
// - normal mode raises interrupt whenever the count reaches its limit
// - a write to a clear register drops that timer's pending interrupt, unless a new event comes in the same cycle
// - a timer starts only after software writes its control with enable set
// - tick timer: 16-bit down counter on core clock, divide 1, 16 or 256
// - tick and general timers may trigger an ADC conversion at their count event
// - general timer: 32-bit up/down, crystal, core, pin or internal oscillator source, divide up to 32768
// - format field selects binary or hours:minutes:seconds:1/128 for load and count
// - general timer captures its count on first assertion of a chosen interrupt
// - wake timer: 32-bit up/down, crystal, core or internal oscillator source
// - wake timer keeps counting while the core clock is gated off
// - watchdog timer normal mode: like tick timer, can count up, 32 kHz source
// - control bit 5 enters watchdog mode; load must be written first
// - watchdog mode counts down from load to zero on the 32 kHz source
// - watchdog expiry gives chip reset or interrupt, chosen by control bit 1
// - any write to the watchdog clear register reloads and restarts the timeout
// - in watchdog mode load and control ignore writes until reset
`ifndef QTW_CFG_SVH
`define QTW_CFG_SVH

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define QTW_TMR_STRIDE_SH 5
`define QTW_OFS_LOAD 5'h00
`define QTW_OFS_COUNT 5'h04
`define QTW_OFS_CTRL 5'h08
`define QTW_OFS_CLEAR 5'h0c
`define QTW_OFS_CAPTURE 5'h10
`define QTW_OFS_STATUS 8'h80
`define QTW_GP_TIMER 2'd1

// ------------------------------------------------------------
// control fields
// ------------------------------------------------------------
`define QTW_CTRL_W 17
`define QTW_CB_DOGRST 1
`define QTW_CB_PRE_LO 2
`define QTW_CB_FMT_LO 4
`define QTW_CB_DOGEN 5
`define QTW_CB_PER 6
`define QTW_CB_EN 7
`define QTW_CB_UP 8
`define QTW_CB_SRC_LO 9
`define QTW_CB_CAP_LO 11
`define QTW_CB_ADCEN 16
`define QTW_FMT_HMS 2'b01
`define QTW_CTRL_RESET 17'h00000

// ------------------------------------------------------------
// time-of-day layout and prescaler limits
// ------------------------------------------------------------
`define QTW_HMS_FULL 32'h173b3b7f
`define QTW_HMS_LO '{0, 8, 16, 24}
`define QTW_HMS_MAX '{7'h7f, 7'h3b, 7'h3b, 7'h17}
`define QTW_PRE_LIM1 15'h0000
`define QTW_PRE_LIM16 15'h000f
`define QTW_PRE_LIM256 15'h00ff
`define QTW_PRE_LIM32K 15'h7fff

`endif

// file: core/qtw_pkg.sv
// types shared by the quad timer block
package qtw_pkg;
  typedef enum logic [1:0] {QTW_PRE_1, QTW_PRE_16, QTW_PRE_256, QTW_PRE_32K} qtw_pre_t;
  typedef enum logic [1:0] {QTW_SRC_XTAL, QTW_SRC_CORE, QTW_SRC_AUX, QTW_SRC_OSC} qtw_src_t;
endpackage

// file: testbench/qtw_timers_chk.sv
// port checker for the quad timer block
`timescale 1ns/1ps
`default_nettype none
module qtw_timers_chk (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [3:0] irq_o,
  input wire logic adc_start_o,
  input wire logic chip_reset_o
);
  logic wr_acc;
  logic [3:0] clr_mask;
  logic ctl_seen_reg;
  logic dog_seen_reg;
  // ------------------------------------------------------------
  // helper logic
  // ------------------------------------------------------------
  assign wr_acc = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o && !paddr_i[7];
  assign clr_mask = (wr_acc && paddr_i[4:0] == 5'h0c) ? 4'h1 << paddr_i[6:5] : 4'h0;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) ctl_seen_reg <= 1'b0;
    else if (wr_acc && paddr_i[4:0] == 5'h08) ctl_seen_reg <= 1'b1;
  end
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) dog_seen_reg <= 1'b0;
    else if (wr_acc && paddr_i == 8'h68 && pwdata_i[5]) dog_seen_reg <= 1'b1;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  apb_answer_a: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no answer after setup");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  err_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  unmapped_err_a: assert property (psel_i && !penable_i && (paddr_i[1:0] != 2'b00 ||
    paddr_i > 8'h80) |=> pslverr_o)
    else $error("unmapped access not refused");
  no_early_count_a: assert property (!ctl_seen_reg |-> irq_o == 4'h0 && !adc_start_o && !chip_reset_o)
    else $error("activity before control write");
  irq_clear_a: assert property (|clr_mask |-> ##2 (irq_o & $past(clr_mask, 2)) == 4'h0)
    else $error("interrupt not cleared");
  adc_pulse_a: assert property (adc_start_o |=> !adc_start_o)
    else $error("conversion start too long");
  adc_cause_a: assert property (adc_start_o |-> irq_o[0] || irq_o[1])
    else $error("conversion start without event");
  dog_pulse_a: assert property (chip_reset_o |=> !chip_reset_o)
    else $error("chip reset too long");
  dog_cause_a: assert property (chip_reset_o |-> dog_seen_reg)
    else $error("chip reset outside watchdog mode");
endmodule
bind qtw_timers qtw_timers_chk u_chk (.core_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .irq_o, .adc_start_o, .chip_reset_o);
`default_nettype wire

// file: testbench/tb.sv
// self-checking testbench of the quad timer block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
  $display("Error at %0t: got %0h expected %0h", $time, got, exp); end end
module tb;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic src_clk = 1'b0;
  logic core_gated_i = 1'b0;
  logic [31:0] irq_src_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic [3:0] irq_o;
  logic adc_start_o;
  logic chip_reset_o;
  logic [31:0] rd;
  logic err;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int resets_seen = 0;

  qtw_timers u_dut (.core_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .xtal32k_i(src_clk), .osc32k_i(src_clk),
    .ext_clk_i(src_clk), .core_gated_i, .irq_src_i, .irq_o, .adc_start_o, .chip_reset_o);

  always #2.5 core_clk_i = ~core_clk_i;

  always @(posedge core_clk_i) begin
    cycles++;
    if (chip_reset_o === 1'b1) resets_seen++;
    if (cycles == 30000) begin
      mismatches++;
      $display("Error at %0t: timeout", $time);
      wrap_up();
    end
  end

  // ------------------------------------------------------------
  // bus and stimulus tasks
  // ------------------------------------------------------------
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do @(posedge core_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
  endtask

  // slow source clock edges, well apart from the core clock
  task automatic ticks(input int n);
    repeat (n) begin
      src_clk <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      src_clk <= 1'b0;
      repeat (4) @(posedge core_clk_i);
    end
    repeat (6) @(posedge core_clk_i);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    repeat (20) @(posedge core_clk_i);
    for (int a = 0; a < 128; a += 32) begin
      for (int o = 0; o < 12; o += 4) begin
        apb(1'b0, 8'(a + o), 32'h0);
        `CHK(rd, 32'h0)
      end
    end
    apb(1'b0, 8'h80, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(irq_o, 4'h0)
  endtask

  task automatic t_errors();
    apb(1'b0, 8'h84, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    apb(1'b1, 8'h02, 32'h5);
    `CHK(err, 1'b1)
    apb(1'b0, 8'h0c, 32'h0);
    `CHK({err, rd}, {1'b0, 32'h0})
  endtask

  task automatic t_tick();
    int gap;
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, 8'h00, 32'h3);
      apb(1'b1, 8'h08, 32'h100c0 | (p << 2));
      do @(posedge core_clk_i); while (adc_start_o !== 1'b1);
      gap = 0;
      do begin @(posedge core_clk_i); gap++; end while (adc_start_o !== 1'b1);
      `CHK(gap, (p == 3) ? 1024 : (4 << (4 * p)))
      apb(1'b0, 8'h04, 32'h0);
      `CHK(rd <= 32'h3, 1'b1)
      `CHK(irq_o[0], 1'b1)
      apb(1'b1, 8'h08, 32'h0);
      apb(1'b1, 8'h0c, 32'h5a);
      repeat (3) @(posedge core_clk_i);
      `CHK(irq_o[0], 1'b0)
      apb(1'b0, 8'h80, 32'h0);
      `CHK(rd[0], 1'b0)
    end
    apb(1'b1, 8'h08, 32'h80);
    apb(1'b0, 8'h04, 32'h0);
    `CHK(rd > 32'hfff0 && rd <= 32'hffff, 1'b1)
    apb(1'b1, 8'h08, 32'h0);
  endtask

  task automatic t_gp();
    int gap;
    logic [31:0] first_rd;
    apb(1'b1, 8'h20, 32'hfffffffc);
    apb(1'b1, 8'h28, 32'h113c0);
    do @(posedge core_clk_i); while (adc_start_o !== 1'b1);
    gap = 0;
    do begin @(posedge core_clk_i); gap++; end while (adc_start_o !== 1'b1);
    `CHK(gap, 4)
    irq_src_i <= 32'h4;
    apb(1'b0, 8'h30, 32'h0);
    `CHK(rd >= 32'hfffffffc, 1'b1)
    apb(1'b1, 8'h28, 32'h0);
    apb(1'b1, 8'h2c, 32'h0);
    irq_src_i <= 32'h0;
    apb(1'b1, 8'h28, 32'h180);
    apb(1'b1, 8'h48, 32'h580);
    core_gated_i <= 1'b1;
    ticks(5);
    apb(1'b0, 8'h24, 32'h0);
    first_rd = rd;
    apb(1'b0, 8'h24, 32'h0);
    `CHK(rd, first_rd)
    `CHK(rd, 32'h5)
    apb(1'b0, 8'h44, 32'h0);
    `CHK(rd, 32'h5)
    core_gated_i <= 1'b0;
    apb(1'b1, 8'h48, 32'h0);
    // wake timer, periodic down from 1 on the core source
    apb(1'b1, 8'h40, 32'h1);
    apb(1'b1, 8'h48, 32'h2c0);
    repeat (8) @(posedge core_clk_i);
    `CHK(irq_o[2], 1'b1)
    apb(1'b1, 8'h48, 32'h0);
    apb(1'b1, 8'h4c, 32'h0);
    repeat (3) @(posedge core_clk_i);
    `CHK(irq_o[2], 1'b0)
    apb(1'b1, 8'h20, 32'h013b3b7f);
    apb(1'b1, 8'h28, 32'h1d0);
    ticks(1);
    apb(1'b0, 8'h24, 32'h0);
    `CHK(rd, 32'h02000000)
    apb(1'b1, 8'h28, 32'h0);
  endtask

  task automatic t_dog();
    apb(1'b1, 8'h60, 32'ha);
    apb(1'b1, 8'h68, 32'ha2);
    ticks(8);
    apb(1'b1, 8'h6c, 32'h0);
    ticks(8);
    `CHK(resets_seen, 0)
    apb(1'b1, 8'h60, 32'h4);
    apb(1'b1, 8'h68, 32'h0);
    apb(1'b0, 8'h60, 32'h0);
    `CHK(rd, 32'ha)
    apb(1'b0, 8'h80, 32'h0);
    `CHK(rd[4], 1'b1)
    ticks(4);
    `CHK(resets_seen, 1)
    do_reset();
    apb(1'b0, 8'h80, 32'h0);
    `CHK(rd[4], 1'b0)
    apb(1'b1, 8'h60, 32'h3);
    apb(1'b1, 8'h68, 32'ha0);
    ticks(5);
    `CHK(irq_o[3], 1'b1)
    `CHK(resets_seen, 1)
    apb(1'b1, 8'h6c, 32'h0);
    repeat (3) @(posedge core_clk_i);
    `CHK(irq_o[3], 1'b0)
  endtask

  initial begin
    do_reset();
    t_reset();
    t_errors();
    t_tick();
    t_gp();
    t_dog();
    wrap_up();
  end
endmodule
`default_nettype wire
